// ===== tsl_touch_latch.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [R1] Input n drives only output n
// [R2] Channel count is 7 or 16
// [R3] Oscillator rate settable, 50 to 100 kHz
// [R4] Touch is level drop versus reference
// [R5] Selected output drives rail, else high impedance
// [R6] Momentary: output active only while touched
// [R7] Open mode pin means momentary, reads 0
// [R8] Mode 1: qualified touch sets latch, stays
// [R9] Each further touch inverts latched output
// [R10] Mode pulse to 0 clears toggle latches
// [R11] Scan clock out at oscillator rate
// [R12] Option locks low channels in momentary
// [R13] Mode 0: locked builds behave like plain
// [R14] Mode may come from own toggle output
// [R15] Touch must persist the switch delay
// [R16] Per-channel counter, clears when touch gone
module tsl_touch_latch #(
    parameter int CHANNELS = tsl_pkg::CHANNELS_LARGE,
    parameter int LOCKED = tsl_pkg::LOCK_NONE,
    parameter int OSC_HZ = tsl_pkg::OSC_DEFAULT_HZ,
    parameter int QUAL_COUNT = tsl_pkg::QUAL_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [CHANNELS-1:0] pad_level_low,
    input wire logic mode_toggle,
    output logic [CHANNELS-1:0] output_drive,
    output logic [CHANNELS-1:0] output_enable,
    output logic panel_scan_clock_out
);

    localparam int HALF = tsl_pkg::CLOCK_HZ / (2 * OSC_HZ);
    localparam int QW = tsl_pkg::QUAL_WIDTH;

    // ****************************************
    // Elaboration checks
    // ****************************************
    initial
    begin
        if (CHANNELS != tsl_pkg::CHANNELS_SMALL && CHANNELS != tsl_pkg::CHANNELS_LARGE) // R2
        begin
            $error("Channel count must be 7 or 16");
        end
        if (LOCKED != tsl_pkg::LOCK_NONE && LOCKED != tsl_pkg::LOCK_LOW4
            && !(LOCKED == tsl_pkg::LOCK_LOW8 && CHANNELS == tsl_pkg::CHANNELS_LARGE)) // R12
        begin
            $error("Unsupported locked channel option");
        end
        if (OSC_HZ < tsl_pkg::OSC_MIN_HZ || OSC_HZ > tsl_pkg::OSC_MAX_HZ) // R3
        begin
            $error("Oscillator rate out of range");
        end
        if (QUAL_COUNT < 1 || QUAL_COUNT >= (1 << QW))
        begin
            $error("Qualification count out of range");
        end
    end

    // ****************************************
    // Oscillator and scan clock
    // ****************************************
    logic osc_tick;
    logic scan_level;

    tsl_osc_divider #(
        .HALF_PERIOD(HALF)
    ) u_osc (
        .clock(clock),
        .reset(reset),
        .osc_tick(osc_tick),
        .scan_level(scan_level)
    );

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            panel_scan_clock_out <= tsl_pkg::RESET_SCAN;
        end
        else
        begin
            panel_scan_clock_out <= scan_level; // R11
        end
    end

    // ****************************************
    // Mode pin: falling edge (high to low) clears toggle latches
    // ****************************************
    logic mode_prev;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            mode_prev <= 1'h0;
        end
        else
        begin
            mode_prev <= mode_toggle; // R7
        end
    end

    // ****************************************
    // Per-channel qualification and latch
    // ****************************************
    logic [QW-1:0] qual_count [CHANNELS];
    logic [CHANNELS-1:0] qualified;
    logic [CHANNELS-1:0] qualified_prev;
    logic [CHANNELS-1:0] latch;
    logic clear_all;

    // Channel follows its pad when locked or mode pin is low
    function automatic logic is_momentary(input int index, input logic toggle);
        return (index < LOCKED) || !toggle;
    endfunction : is_momentary

    // Counter has reached the qualification count
    function automatic logic count_done(input logic [QW-1:0] value);
        return value == QW'(QUAL_COUNT);
    endfunction : count_done

    assign clear_all = mode_prev && !mode_toggle; // R10

    // Pad level drop is judged against the reference off-chip
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (reset || !pad_level_low[i]) // R4 R16
            begin
                qual_count[i] <= '0;
            end
            else if (osc_tick && !count_done(qual_count[i]))
            begin
                qual_count[i] <= qual_count[i] + QW'(1); // R16
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            qualified <= '0;
        end
        else
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                qualified[i] <= pad_level_low[i] && count_done(qual_count[i]); // R15
            end
        end
    end

    // ****************************************
    // Toggle latches
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            qualified_prev <= '0;
            latch <= {CHANNELS{tsl_pkg::RESET_LATCH}};
        end
        else
        begin
            qualified_prev <= qualified;
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (clear_all)
                begin
                    latch[i] <= 1'h0; // R10
                end
                else if (mode_toggle && qualified[i] && !qualified_prev[i])
                begin
                    latch[i] <= ~latch[i]; // R8 R9
                end
            end
        end
    end

    // ****************************************
    // Output stage
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            output_enable <= '0;
            output_drive <= '0;
        end
        else
        begin
            output_drive <= '1; // R5
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (is_momentary(i, mode_toggle)) // R12 R13
                begin
                    output_enable[i] <= qualified[i]; // R1 R6
                end
                else
                begin
                    output_enable[i] <= latch[i]; // R1 R14
                end
            end
        end
    end

endmodule : tsl_touch_latch

`default_nettype wire

// ===== tsl_pkg.sv
package tsl_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_HZ = 100_000_000;
    localparam int OSC_MIN_HZ = 50_000;
    localparam int OSC_MAX_HZ = 100_000;
    localparam int OSC_DEFAULT_HZ = 50_000;
    localparam int SWITCH_DELAY_MIN_MS = 50;
    localparam int SWITCH_DELAY_TYP_MS = 100;
    localparam int SWITCH_DELAY_MAX_MS = 200;
    // Oscillator cycles for a least switch delay at 50 kHz, rounded up
    localparam int QUAL_CYCLES = (SWITCH_DELAY_MIN_MS * OSC_MIN_HZ + 999) / 1000;
    localparam int QUAL_WIDTH = 16;

    // ****************************************
    // Channel counts and lock options
    // ****************************************
    localparam int CHANNELS_SMALL = 7;
    localparam int CHANNELS_LARGE = 16;
    localparam int LOCK_NONE = 0;
    localparam int LOCK_LOW4 = 4;
    localparam int LOCK_LOW8 = 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RESET_LATCH = 1'h0;
    localparam logic RESET_SCAN = 1'h0;

endpackage : tsl_pkg

// ===== tsl_osc_divider.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Oscillator divider: tick at osc rate, scan clock square wave
// ****************************************
module tsl_osc_divider #(
    parameter int HALF_PERIOD = 1000
) (
    input wire logic clock,
    input wire logic reset,
    output logic osc_tick,
    output logic scan_level
);

    localparam int CW = $clog2(HALF_PERIOD + 1);

    logic [CW-1:0] count;

    initial
    begin
        if (HALF_PERIOD < 1)
        begin
            $error("Divider half period too small");
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            count <= '0;
            scan_level <= tsl_pkg::RESET_SCAN;
            osc_tick <= 1'h0;
        end
        else if (count == CW'(HALF_PERIOD - 1))
        begin
            count <= '0;
            scan_level <= ~scan_level;
            osc_tick <= scan_level;
        end
        else
        begin
            count <= count + CW'(1);
            osc_tick <= 1'h0;
        end
    end

endmodule : tsl_osc_divider

`default_nettype wire

// ===== tsl_touch_latch_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checks
// ****
module tsl_touch_latch_chk #(
    parameter int CHANNELS = 16,
    parameter int LOCKED = 0,
    parameter int OSC_HZ = 50000,
    parameter int QUAL_COUNT = 2500
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [CHANNELS-1:0] pad_level_low,
    input wire logic mode_toggle,
    input wire logic [CHANNELS-1:0] output_drive,
    input wire logic [CHANNELS-1:0] output_enable,
    input wire logic panel_scan_clock_out
);
    localparam int HALF = tsl_pkg::CLOCK_HZ / OSC_HZ / 2;
    localparam int T = LOCKED;
    int held;
    int cnt;
    logic prev;
    logic seen;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    always_ff @(posedge clock)
    begin
        held <= pad_level_low[0] ? held + 1 : 0;
        prev <= panel_scan_clock_out;
        cnt <= (panel_scan_clock_out != prev) ? 0 : cnt + 1;
        seen <= reset ? 1'h0 : (seen | (panel_scan_clock_out != prev));
    end
    sequence clr_pulse;
        (pad_level_low == '0)[*2] ##0 $fell(mode_toggle) ##1
            (mode_toggle && pad_level_low == '0)[*2];
    endsequence
    chk_untouched_off: assert property (
        (!pad_level_low[0] && (T > 0 || !mode_toggle)) ##1
            (!pad_level_low[0] && (T > 0 || !mode_toggle)) |=> !output_enable[0])
        else $error("on untouched");
    chk_touch_delay: assert property (
        $rose(output_enable[0]) |-> held >= (QUAL_COUNT - 1) * 2 * HALF) else $error("too early");
    chk_touch_stands: assert property (
        pad_level_low[0] ##1 (pad_level_low[0] && output_enable[0]) |=> output_enable[0])
        else $error("dropped while touched");
    chk_drive_rail: assert property (!$past(reset) |-> &output_drive)
        else $error("drive not rail");
    chk_toggle_hold: assert property (
        (mode_toggle && !pad_level_low[T])[*3] ##1 mode_toggle |-> $stable(output_enable[T]))
        else $error("latch moved");
    chk_clear_all: assert property (clr_pulse |=> output_enable == '0)
        else $error("not cleared");
    chk_scan_period: assert property (
        seen && panel_scan_clock_out != prev |-> cnt == HALF - 1) else $error("scan period");
    chk_index_only: assert property (
        $rose(output_enable[1]) |-> $past(pad_level_low[1])) else $error("cross channel");
    cover property ($rose(output_enable[T]));
    cover property (clr_pulse);
    cover property ($fell(output_enable[0]));
endmodule : tsl_touch_latch_chk
bind tsl_touch_latch tsl_touch_latch_chk #(.CHANNELS(CHANNELS), .LOCKED(LOCKED),
    .OSC_HZ(OSC_HZ), .QUAL_COUNT(QUAL_COUNT)) chk (.clock(clock), .reset(reset),
    .pad_level_low(pad_level_low), .mode_toggle(mode_toggle), .output_drive(output_drive),
    .output_enable(output_enable), .panel_scan_clock_out(panel_scan_clock_out));
`default_nettype wire

// ===== tsl_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Pads and mode pin
// ****
module tsl_pad_model #(
    parameter int CHANNELS = 16
) (
    input wire logic [CHANNELS-1:0] touch,
    input wire logic bounce,
    input wire logic mode_wired,
    input wire logic mode_level,
    output logic [CHANNELS-1:0] pad_level_low,
    output logic mode_toggle
);
    assign pad_level_low = bounce ? '0 : touch;
    assign mode_toggle = mode_wired & mode_level;
endmodule : tsl_pad_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Bench
// ****
module tb;
    localparam int N = 7;
    localparam int LK = 4;
    localparam int HOLD = 4500;
    localparam int SCAN_HALF = tsl_pkg::CLOCK_HZ / (2 * 100000);
    localparam logic [N-1:0] LKM = N'((1 << LK) - 1);
    logic clock;
    logic reset;
    logic [N-1:0] touch;
    logic bounce;
    logic mode_wired;
    logic mode_level;
    logic [N-1:0] pad;
    logic mode;
    logic [N-1:0] oe;
    logic [N-1:0] latch;
    logic [N-1:0] m;
    logic [N-1:0] drv;
    logic scan;
    logic sc;
    int seed;
    int len;
    int err_count;
    int n_tests;
    tsl_pad_model #(.CHANNELS(N)) pads (.touch(touch), .bounce(bounce), .mode_wired(mode_wired),
        .mode_level(mode_level), .pad_level_low(pad), .mode_toggle(mode));
    tsl_touch_latch #(.CHANNELS(N), .LOCKED(LK), .OSC_HZ(100000), .QUAL_COUNT(3)) dut (
        .clock(clock), .reset(reset), .pad_level_low(pad), .mode_toggle(mode),
        .output_drive(drv), .output_enable(oe), .panel_scan_clock_out(scan));
    function automatic logic [N-1:0] expect_oe(input logic [N-1:0] t, input logic tog);
        return tog ? ((t & LKM) | (latch & ~LKM)) : t;
    endfunction : expect_oe
    task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic hold(input logic [N-1:0] t, input int n);
        @(negedge clock);
        touch = t;
        repeat (n) @(negedge clock);
    endtask : hold
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #500000;
        err_count++;
        finish_test();
    end
    initial
    begin
        seed = 495;
        touch = '0;
        bounce = 1'h0;
        mode_wired = 1'h0;
        mode_level = 1'h1;
        latch = '0;
        err_count = 0;
        n_tests = 0;
        reset = 1'h1;
        repeat (2) @(negedge clock);
        reset = 1'h0;
        @(negedge clock);
        check(oe, '0);
        repeat (3)
        begin
            m = N'($random(seed));
            hold(m, HOLD);
            check(oe, expect_oe(m, 1'h0));
            hold('0, 5);
            check(oe, '0);
        end
        check(drv, '1);
        sc = scan;
        repeat (SCAN_HALF) @(negedge clock);
        check(N'(scan), N'(!sc));
        $display("momentary done");
        len = 500 + ($random(seed) & 32'h3ff);
        hold(m, len);
        bounce = 1'h1;
        @(negedge clock);
        bounce = 1'h0;
        hold(m, len);
        check(oe, '0);
        hold('0, 5);
        $display("short touch done");
        mode_wired = 1'h1;
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2)
                m = N'($random(seed));
            hold(m, HOLD);
            latch = latch ^ (m & ~LKM);
            check(oe, expect_oe(m, 1'h1));
            hold('0, 5);
            check(oe, expect_oe('0, 1'h1));
        end
        $display("toggle done");
        mode_level = 1'h0;
        @(negedge clock);
        mode_level = 1'h1;
        latch = '0;
        repeat (5) @(negedge clock);
        check(oe, '0);
        $display("clear done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
